// [hw/ses_status.sv]
// Contract
// (R1) event bit 0 sets once commands through the completion marker have run
// (R2) query-class errors set event bit 2
// (R3) self-test or calibration errors set event bit 3
// (R4) execution errors set event bit 4
// (R5) command syntax errors set event bit 5
// (R6) event bit 7 set after power-up until event register read or cleared
// (R7) event bits latch until cleared
// (R8) clear-status and event query both clear the event register
// (R9) event-enable write loads the mask; zero clears it
// (R10) status bit 5 is OR of enabled event bits
// (R11) nonvolatile power-on clear flag, factory 1, zeroes both masks at power-up
// (R12) every event bit 2..5 comes with an error queue entry
// (R13) queue of 20 errors, oldest first, one per read
// (R14) overflow overwrites newest with -350, stores none until a read
// (R15) reading an empty queue answers +0
// (R16) indicator on while entries held; one beep per new error
// (R17) queue emptied at power-up and clear-status, not by reset command
// (R18) clear-status clears status summary and event registers
// (R19) queries answer the binary-weighted value of the register
// (R20) completion marker waits for all earlier commands
// (R21) completion query answers 1 once earlier commands are done
// (R22) status query answers poll value in order, keeps bit 6
// (R23) wait command stalls further commands until pending work ends
// (R24) controller polls or waits for a request on status bit 5
`timescale 1ns/1ps
`default_nettype none
`include "ses_defs.svh"

module ses_status #(
    parameter int DEPTH = `SES_ERR_DEPTH
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire ses_pkg::ses_cmd_t CMD,
    input  wire ses_pkg::ses_err_t ERR,
    input  wire logic             BUSY,
    input  wire logic             OUT_AVAIL,
    input  wire logic             POLL,
    input  wire logic             PSC_NV,
    input  wire logic [7:0]       ESE_NV,
    input  wire logic [7:0]       SRE_NV,
    output var  ses_pkg::ses_rsp_t RSP,
    output logic [7:0]            STB_BYTE,
    output logic [7:0]            ESR_FLAGS,
    output logic [7:0]            ESE_MASK,
    output logic [7:0]            SRE_MASK,
    output logic                  PSC_FLAG,
    output logic                  CMD_STALL,
    output logic                  ERR_LED,
    output logic                  BEEP
);
    import ses_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef enum logic [1:0] {SES_RUN, SES_WAIT_WAI, SES_WAIT_OPCQ} ses_wait_t;

    ses_wait_t      wait_r, wait_nxt;
    logic [7:0]     esr_r, ese_r, sre_r;
    logic           psc_r, init_r, opc_pend_r, ovf_r, req_d_r, rqs_r;
    logic [PW-1:0]  rp_r, wp_r;
    logic [CW-1:0]  cnt_r;
    logic [15:0]    q_mem [DEPTH];

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    // while stalled the parser must hold commands; any that arrive are dropped
    wire go      = CMD.valid && (wait_r == SES_RUN);              // R23
    wire is_cls  = go && (CMD.op == SES_OP_CLS);
    wire is_esew = go && (CMD.op == SES_OP_ESE_WR);
    wire is_esr  = go && (CMD.op == SES_OP_ESR_RD);
    wire is_opc  = go && (CMD.op == SES_OP_OPC);
    wire is_srew = go && (CMD.op == SES_OP_SRE_WR);
    wire is_pscw = go && (CMD.op == SES_OP_PSC_WR);
    wire is_errq = go && (CMD.op == SES_OP_ERR_RD);

    // ----------------------------------------
    // completion tracking
    // ----------------------------------------
    wire opc_fire  = (opc_pend_r || is_opc) && !BUSY;             // R1 R20
    wire opcq_done = (wait_r == SES_WAIT_OPCQ) && !BUSY;          // R21

    always_comb begin
        wait_nxt = wait_r;
        case (wait_r)
            SES_RUN: begin
                if (go && CMD.op == SES_OP_WAI && BUSY)
                    wait_nxt = SES_WAIT_WAI;                      // R23
                else if (go && CMD.op == SES_OP_OPC_RD)
                    wait_nxt = SES_WAIT_OPCQ;
            end
            SES_WAIT_WAI:  if (!BUSY) wait_nxt = SES_RUN;         // R23
            SES_WAIT_OPCQ: if (!BUSY) wait_nxt = SES_RUN;
            default:       wait_nxt = SES_RUN;
        endcase
    end

    // ----------------------------------------
    // event register
    // ----------------------------------------
    // new events win over a clear in the same cycle so none is lost
    wire [7:0] err_bits = ERR.valid ? 8'(8'h01 << (`SES_EV_QUERY + ERR.cls)) : 8'h00; // R2 R3 R4 R5 R12
    wire [7:0] ev_set   = err_bits | {7'h00, opc_fire};           // R1
    wire       esr_clr  = is_cls || is_esr;                       // R8 R18 R6
    wire [7:0] esr_nxt  = ((esr_clr ? 8'h00 : esr_r) | ev_set) & `SES_EV_USED; // R7

    // ----------------------------------------
    // status byte and service request
    // ----------------------------------------
    wire       esb      = |(esr_nxt & ese_r);                     // R10
    wire [7:0] sum_norq = 8'(({7'h00, esb} << `SES_STB_ESB)
                          | ({7'h00, OUT_AVAIL} << `SES_STB_MAV));
    wire       req      = |(sum_norq & sre_r);
    // request latches on a rising source, a poll clears it, a gone source drops it
    wire       rqs_nxt  = (req && !req_d_r) || (rqs_r && req && !POLL && !is_cls);
    wire [7:0] stb_nxt  = sum_norq | 8'({7'h00, rqs_nxt} << `SES_STB_RQS);

    // ----------------------------------------
    // error queue pointers
    // ----------------------------------------
    wire           pop      = is_errq && (cnt_r != '0);           // R13
    wire [CW-1:0]  cnt_base = is_cls ? '0 : CW'(cnt_r - CW'(pop)); // R17
    wire [PW-1:0]  rp_inc   = (rp_r == PW'(DEPTH - 1)) ? '0 : PW'(rp_r + 1'b1);
    wire [PW-1:0]  wp_inc   = (wp_r == PW'(DEPTH - 1)) ? '0 : PW'(wp_r + 1'b1);
    wire [PW-1:0]  wp_last  = (wp_r == '0) ? PW'(DEPTH - 1) : PW'(wp_r - 1'b1);
    wire           ovf_base = ovf_r && !pop && !is_cls;           // R14
    wire           push     = ERR.valid && (cnt_base != FULL);    // R12
    wire           ovwr     = ERR.valid && (cnt_base == FULL) && !ovf_base; // R14
    wire [PW-1:0]  wp_base  = is_cls ? '0 : wp_r;
    wire [PW-1:0]  wp_next  = is_cls ? PW'(push) : (push ? wp_inc : wp_r);
    wire [PW-1:0]  rp_next  = is_cls ? '0 : (pop ? rp_inc : rp_r);
    wire [CW-1:0]  cnt_nxt  = CW'(cnt_base + CW'(push));

    // entry writes; overflow replaces the newest entry in place
    always_ff @(posedge CLK) begin
        if (push)
            q_mem[wp_base] <= ERR.code;                           // R13
        else if (ovwr)
            q_mem[wp_last] <= `SES_ERR_OVF;                       // R14
    end

    // ----------------------------------------
    // query answer select
    // ----------------------------------------
    logic        rsp_go;
    logic [15:0] rsp_val;
    always_comb begin
        rsp_go  = go;
        rsp_val = 16'h0000;
        case (CMD.op)
            SES_OP_ESE_RD: rsp_val = {8'h00, ese_r};              // R19
            SES_OP_ESR_RD: rsp_val = {8'h00, esr_r};              // R19
            SES_OP_SRE_RD: rsp_val = {8'h00, sre_r};
            SES_OP_STB_RD: rsp_val = {8'h00, STB_BYTE};           // R22
            SES_OP_PSC_RD: rsp_val = {15'h0000, psc_r};           // R11
            SES_OP_ERR_RD: rsp_val = pop ? q_mem[rp_r] : `SES_ERR_NONE; // R15
            default:       rsp_go  = 1'b0;
        endcase
        if (opcq_done) begin
            rsp_go  = 1'b1;
            rsp_val = `SES_OPCQ_ANS;                              // R21
        end
    end

    // ----------------------------------------
    // wait state and event register
    // ----------------------------------------
    // a reset always lands in run, so a stall cannot outlive power-up
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_r <= SES_RUN;
        end else begin
            wait_r <= wait_nxt;                                   // R23
        end
    end

    // power-up leaves only the power event standing
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            esr_r <= `SES_EV_RESET;                               // R6
        end else begin
            esr_r <= esr_nxt;                                     // R7
        end
    end

    // ----------------------------------------
    // completion, request, mask, flag and queue state
    // ----------------------------------------
    // clear-status drops a pending marker so no stale bit 0 shows up later
    wire opc_pend_nxt = (opc_pend_r || is_opc) && BUSY && !is_cls; // R20

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            opc_pend_r <= 1'b0;
        end else begin
            opc_pend_r <= opc_pend_nxt;                           // R1
        end
    end

    // last source level; starts low so a source up at power-up still requests
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_d_r <= 1'b0;
        end else begin
            req_d_r <= req;
        end
    end

    // service request bit; only a poll, clear-status or a gone source drops it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rqs_r <= 1'b0;
        end else begin
            rqs_r <= rqs_nxt;                                     // R22
        end
    end

    // masks and flag; nonvolatile values are taken one edge after release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            init_r <= 1'b0;
            psc_r  <= `SES_PSC_FACTORY;
            ese_r  <= 8'h00;
            sre_r  <= 8'h00;
        end else if (!init_r) begin
            init_r <= 1'b1;
            psc_r  <= PSC_NV;
            ese_r  <= PSC_NV ? 8'h00 : ESE_NV;                    // R11
            sre_r  <= PSC_NV ? 8'h00 : SRE_NV;                    // R11
        end else begin
            if (is_pscw) psc_r <= CMD.arg[0];                     // R11
            if (is_esew) ese_r <= CMD.arg;                        // R9
            if (is_srew) sre_r <= CMD.arg;
        end
    end

    // queue pointers; the reset command does not reach here
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rp_r  <= '0;                                          // R17
            wp_r  <= '0;
            cnt_r <= '0;
        end else begin
            rp_r  <= rp_next;                                     // R13
            wp_r  <= wp_next;
            cnt_r <= cnt_nxt;
        end
    end

    // overflow mark blocks a second overflow entry until a read makes room or the queue is cleared
    wire ovf_nxt = ovf_base || ovwr;                              // R14

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // answer strobe and data leave together, on the taking edge or, for the completion query, on the edge its wait ends
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RSP <= '0;
        end else begin
            RSP.valid <= rsp_go;                                  // R19
            RSP.data  <= rsp_val;
        end
    end

    // status copies come from the next values so both show the same edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            STB_BYTE  <= 8'h00;
            ESR_FLAGS <= `SES_EV_RESET;
        end else begin
            STB_BYTE  <= stb_nxt;                                 // R10 R18
            ESR_FLAGS <= esr_nxt;
        end
    end

    // lamp follows the count after this edge's push and pop
    wire led_nxt = (cnt_nxt != '0);                               // R16

    // stall, lamp and beep; a beep marks even an error dropped by overflow
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CMD_STALL <= 1'b0;
            ERR_LED   <= 1'b0;
            BEEP      <= 1'b0;
        end else begin
            CMD_STALL <= (wait_nxt != SES_RUN);                   // R23
            ERR_LED   <= led_nxt;                                 // R16
            BEEP      <= ERR.valid;                               // R16
        end
    end

    // ----------------------------------------
    // mask and flag copies
    // ----------------------------------------
    // held for the store to nonvolatile memory
    assign ESE_MASK = ese_r;
    assign SRE_MASK = sre_r;
    assign PSC_FLAG = psc_r;

endmodule
`default_nettype wire

// [hw/ses_defs.svh]
`ifndef SES_DEFS_SVH
`define SES_DEFS_SVH
// ----------------------------------------
// event bit positions, used-bit mask and reset value
// ----------------------------------------
`define SES_EV_OPC      0
`define SES_EV_QUERY    2
`define SES_EV_PWR      7
`define SES_EV_USED     8'hBD
`define SES_EV_RESET    8'h80
// ----------------------------------------
// status byte positions
// ----------------------------------------
`define SES_STB_MAV     4
`define SES_STB_ESB     5
`define SES_STB_RQS     6
// ----------------------------------------
// error queue, completion answer and power-on flag
// ----------------------------------------
`define SES_ERR_DEPTH   20
`define SES_ERR_OVF     16'hFEA2
`define SES_ERR_NONE    16'h0000
`define SES_OPCQ_ANS    16'h0001
`define SES_PSC_FACTORY 1'b1
`endif

// [hw/ses_pkg.sv]
package ses_pkg;
    // ----------------------------------------
    // commands handed over by the parser
    // ----------------------------------------
    typedef enum logic [3:0] {
        SES_OP_CLS, SES_OP_ESE_WR, SES_OP_ESE_RD, SES_OP_ESR_RD,
        SES_OP_OPC, SES_OP_OPC_RD, SES_OP_PSC_WR, SES_OP_PSC_RD,
        SES_OP_SRE_WR, SES_OP_SRE_RD, SES_OP_STB_RD, SES_OP_WAI,
        SES_OP_ERR_RD, SES_OP_RST
    } ses_op_t;

    typedef struct packed {
        logic       valid;
        ses_op_t    op;
        logic [7:0] arg;
    } ses_cmd_t;

    // error report: class 0 query, 1 device, 2 execution, 3 command
    typedef struct packed {
        logic        valid;
        logic [1:0]  cls;
        logic [15:0] code;
    } ses_err_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ses_rsp_t;
endpackage

// [tb/ses_status_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ses_status_chk (
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire ses_pkg::ses_cmd_t CMD,
    input wire ses_pkg::ses_err_t ERR,
    input wire logic              BUSY,
    input wire ses_pkg::ses_rsp_t RSP,
    input wire logic [7:0]        STB_BYTE,
    input wire logic [7:0]        ESR_FLAGS,
    input wire logic [7:0]        ESE_MASK,
    input wire logic              CMD_STALL,
    input wire logic              ERR_LED,
    input wire logic              BEEP
);
    import ses_pkg::*;
    // ----------------------------------------
    // port-level relations
    // ----------------------------------------
    // a command counts only when the stall is low
    wire logic tk = CMD.valid && !CMD_STALL;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_beep; ERR.valid && !(tk && CMD.op == SES_OP_CLS)
        |=> BEEP && ERR_LED; endproperty
    a_beep: assert property (p_beep) else $error("no beep or lamp after error");
    property p_evt; ERR.valid |=> ESR_FLAGS[2 + $past(ERR.cls)]; endproperty
    a_evt: assert property (p_evt) else $error("error class bit not set");
    property p_esr; tk && CMD.op == SES_OP_ESR_RD && !ERR.valid |=> RSP.valid
        && ESR_FLAGS[7:1] == 7'h00 && RSP.data[15:8] == 8'h00; endproperty
    a_esr: assert property (p_esr) else $error("event query did not clear");
    property p_esb; $stable(ESR_FLAGS) && $stable(ESE_MASK)
        |-> STB_BYTE[5] == |(ESR_FLAGS & ESE_MASK); endproperty
    a_esb: assert property (p_esb) else $error("summary bit wrong");
    property p_loose; !ESR_FLAGS[1] && !ESR_FLAGS[6]
        && STB_BYTE[3:0] == 4'h0 && !STB_BYTE[7]; endproperty
    a_loose: assert property (p_loose) else $error("unused bit set");
    property p_hold; CMD_STALL && BUSY |=> CMD_STALL; endproperty
    a_hold: assert property (p_hold) else $error("stall dropped while busy");
    property p_rel; CMD_STALL && !BUSY |=> !CMD_STALL; endproperty
    a_rel: assert property (p_rel) else $error("stall kept after idle");
    // the answer leaves one edge after the wait state has seen idle
    property p_opc; tk && CMD.op == SES_OP_OPC_RD && !BUSY ##1 !BUSY
        |=> RSP.valid && RSP.data == 16'h0001; endproperty
    a_opc: assert property (p_opc) else $error("completion answer missing");
    property p_ese; tk && CMD.op == SES_OP_ESE_WR |=> ESE_MASK == $past(CMD.arg); endproperty
    a_ese: assert property (p_ese) else $error("enable mask not loaded");
endmodule
bind ses_status ses_status_chk i_chk (.*);
`default_nettype wire

// [tb/ses_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// remote controller: commands and polls
// ----------------------------------------
module ses_ctl_model (
    input  wire logic              CLK,
    output var  ses_pkg::ses_cmd_t CMD,
    output logic                   POLL
);
    import ses_pkg::*;
    // idle bus from time zero
    initial begin
        CMD = '0;
        POLL = 1'b0;
    end
    // one command held through its taking edge; stalled ones are lost
    task automatic send(input ses_op_t op, input logic [7:0] arg);
        @(posedge CLK);
        #1 CMD = {1'b1, op, arg};
        @(posedge CLK);
        #1 CMD.valid = 1'b0;
    endtask
    // serial poll: POLL held high through one edge
    task automatic poll();
        @(posedge CLK);
        #1 POLL = 1'b1;
        @(posedge CLK);
        #1 POLL = 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/standard_event_status_and_error_queue_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module standard_event_status_and_error_queue_tb;
    import ses_pkg::*;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic       clk;
    logic       rst_n;
    logic       busy;
    logic       poll;
    logic       psc;
    logic       stall;
    logic       led;
    logic       beep;
    logic [7:0] stb;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic       psc_nv;
    ses_cmd_t   cmd;
    ses_err_t   err;
    ses_rsp_t   rsp;
    int         bad_count = 0;
    int         tests_run = 0;
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ses_ctl_model i_ctl (.CLK(clk), .CMD(cmd), .POLL(poll));
    // small queue so overflow comes quickly
    ses_status #(.DEPTH(4)) i_dut (.CLK(clk), .RST_N(rst_n), .CMD(cmd), .ERR(err),
        .BUSY(busy), .OUT_AVAIL(1'b0), .POLL(poll), .PSC_NV(psc_nv), .ESE_NV(8'hFF),
        .SRE_NV(8'hFF), .RSP(rsp), .STB_BYTE(stb), .ESR_FLAGS(esr), .ESE_MASK(ese),
        .SRE_MASK(sre), .PSC_FLAG(psc), .CMD_STALL(stall), .ERR_LED(led), .BEEP(beep));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // query answered the cycle after its take
    task automatic rd(input ses_op_t op, input logic [15:0] exp, input string what);
        i_ctl.send(op, 8'h00);
        chk({15'h0000, rsp.valid}, 16'h0001, "answer strobe");
        chk(rsp.data, exp, what);
    endtask
    task automatic fault(input logic [1:0] cls, input logic [15:0] code);
        @(posedge clk);
        #1 err = {1'b1, cls, code};
        @(posedge clk);
        #1 err.valid = 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    // test sequence
    initial begin
        rst_n = 1'b0;
        busy = 1'b0;
        err = '0;
        psc_nv = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        chk(16'(ese), 16'h0000, "event mask");
        chk(16'(psc), 16'h0001, "power flag");
        chk(16'(sre), 16'h0000, "status mask");
        rd(SES_OP_ESR_RD, 16'h0080, "power event");
        rd(SES_OP_ESR_RD, 16'h0000, "events");
        rd(SES_OP_PSC_RD, 16'h0001, "flag query");
        $display("test power-up done");
        for (int k = 0; k < 6; k++) begin
            fault(2'(k), 16'(k + 1));
        end
        i_ctl.send(SES_OP_RST, 8'h00);
        chk(16'(led), 16'h0001, "error lamp");
        rd(SES_OP_ESR_RD, 16'h003C, "error events");
        for (int k = 1; k < 4; k++) begin
            rd(SES_OP_ERR_RD, 16'(k), "queued code");
        end
        rd(SES_OP_ERR_RD, 16'hFEA2, "overflow code");
        rd(SES_OP_ERR_RD, 16'h0000, "empty code");
        repeat (2) @(posedge clk);
        chk(16'(led), 16'h0000, "error lamp");
        $display("test error queue done");
        i_ctl.send(SES_OP_SRE_WR, 8'h20);
        i_ctl.send(SES_OP_ESE_WR, 8'h20);
        fault(2'h3, 16'h0005);
        chk(16'(beep), 16'h0001, "beep");
        repeat (2) @(posedge clk);
        chk(16'(stb[5]), 16'h0001, "summary bit");
        #1 chk(16'(stb), 16'h0060, "status byte");
        rd(SES_OP_STB_RD, 16'h0060, "status query");
        chk(16'(stb), 16'h0060, "queried status byte");
        i_ctl.poll();
        chk(16'(stb), 16'h0020, "polled status byte");
        rd(SES_OP_SRE_RD, 16'h0020, "status mask");
        i_ctl.send(SES_OP_ESE_WR, 8'h00);
        repeat (2) @(posedge clk);
        chk(16'(stb[5]), 16'h0000, "summary bit");
        rd(SES_OP_ESE_RD, 16'h0000, "event mask");
        i_ctl.send(SES_OP_CLS, 8'h00);
        rd(SES_OP_ESR_RD, 16'h0000, "cleared events");
        rd(SES_OP_ERR_RD, 16'h0000, "cleared queue");
        i_ctl.send(SES_OP_PSC_WR, 8'h00);
        rd(SES_OP_PSC_RD, 16'h0000, "flag query");
        $display("test mask and clear done");
        busy = 1'b1;
        i_ctl.send(SES_OP_OPC, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk(16'(esr[0]), 16'h0000, "completion");
        busy = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(16'(esr[0]), 16'h0001, "completion");
        i_ctl.send(SES_OP_OPC_RD, 8'h00);
        @(posedge clk);
        #1 chk({15'h0000, rsp.valid}, 16'h0001, "answer strobe");
        chk(rsp.data, 16'h0001, "completion answer");
        busy = 1'b1;
        i_ctl.send(SES_OP_OPC_RD, 8'h00);
        i_ctl.send(SES_OP_ESE_WR, 8'h01);
        chk(16'(stall), 16'h0001, "stall");
        busy = 1'b0;
        for (int n = 0; n < 20 && rsp.valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0000, rsp.valid}, 16'h0001, "answer strobe");
        chk(rsp.data, 16'h0001, "completion answer");
        rd(SES_OP_ESE_RD, 16'h0000, "refused write");
        $display("test completion done");
        busy = 1'b1;
        i_ctl.send(SES_OP_WAI, 8'h00);
        i_ctl.send(SES_OP_ESE_WR, 8'h02);
        chk(16'(stall), 16'h0001, "wait stall");
        busy = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(16'(stall), 16'h0000, "wait release");
        rd(SES_OP_ESE_RD, 16'h0000, "refused write");
        $display("test wait done");
        // stored flag now 0: a second power-up must keep both masks
        fault(2'h1, 16'h0007);
        psc_nv = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(16'(ese), 16'h00FF, "kept event mask");
        chk(16'(sre), 16'h00FF, "kept status mask");
        chk(16'(psc), 16'h0000, "stored flag");
        rd(SES_OP_ERR_RD, 16'h0000, "queue after power-up");
        $display("test power flag done");
        print_verdict();
    end
endmodule
`default_nettype wire
